/* File: common/ubmu_pkg.sv */
// Purpose: Shared constants for the two-channel user break match unit
// Assumes: 32-bit register port, byte addresses in steps of four
// Notes:   Field layouts and offsets are used by top and channel logic

package ubmu_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam int unsigned REG_ADDR_W = 8;
	localparam logic [7:0] OFS_COND   = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_AMASK  = 8'h08;
	localparam logic [7:0] OFS_OPER   = 8'h0C;
	localparam int unsigned CH_STRIDE = 16;
	localparam logic [7:0] OFS_DATA   = 8'h20;
	localparam logic [7:0] OFS_DMASK  = 8'h24;
	localparam logic [7:0] OFS_COUNT  = 8'h28;
	localparam logic [7:0] OFS_FLAGS  = 8'h2C;
	localparam logic [7:0] OFS_CTRL   = 8'h30;

	// ********************************************************
	// Reset values and writable masks
	// ********************************************************
	localparam logic [31:0] RST_WORD   = 32'h00000000;
	localparam logic [31:0] COND_MASK  = 32'h00FF0FFF;
	localparam logic [31:0] OPER_MASK  = 32'h00000003;
	localparam logic [31:0] CTRL_MASK  = 32'h00000001;
	localparam logic [1:0]  FLAGS_RST  = 2'h0;

	// ********************************************************
	// Condition, operation and control register fields
	// ********************************************************
	localparam int unsigned COND_CE    = 0;
	localparam int unsigned COND_RD    = 1;
	localparam int unsigned COND_WR    = 2;
	localparam int unsigned COND_OPCYC = 3;
	localparam int unsigned COND_SZ_LO = 4;
	localparam int unsigned COND_SZ_EN = 6;
	localparam int unsigned COND_DBE   = 7;
	localparam int unsigned COND_EXEC_COUNT_ENABLE  = 8;
	localparam int unsigned COND_AIE   = 9;
	localparam int unsigned COND_MFE   = 10;
	localparam int unsigned COND_MFI   = 11;
	localparam int unsigned COND_AIV_LO = 16;
	localparam int unsigned ASID_W     = 8;
	localparam int unsigned OPER_BIE   = 0;
	localparam int unsigned OPER_AFTER = 1;
	localparam int unsigned CTRL_EN    = 0;

	// ********************************************************
	// Execution count
	// ********************************************************
	localparam int unsigned COUNT_W = 12;
	localparam logic [11:0] COUNT_ONE = 12'h001;

	// ********************************************************
	// Operand sizes, lane masks and access kinds
	// ********************************************************
	typedef enum logic [1:0] {
		OPSZ_BYTE = 2'h0,
		OPSZ_WORD = 2'h1,
		OPSZ_LONG = 2'h2,
		OPSZ_QUAD = 2'h3
	} ubmu_size_t;

	localparam logic [31:0] LANE_BYTE = 32'h000000FF;
	localparam logic [31:0] LANE_WORD = 32'h0000FFFF;
	localparam logic [31:0] LANE_LONG = 32'hFFFFFFFF;

	typedef enum logic [2:0] {
		OPK_NORMAL   = 3'h0,
		OPK_PREFETCH = 3'h1,
		OPK_PURGE    = 3'h2,
		OPK_WRBACK   = 3'h3,
		OPK_ALLOC    = 3'h4,
		OPK_INVAL    = 3'h5,
		OPK_TAS      = 3'h6
	} ubmu_kind_t;

endpackage : ubmu_pkg

/* File: logic/ubmu_chan_match.sv */
// Purpose: Combinational match of one channel against fetch and operand
// Assumes: Operand direction and size already classified by the caller
// Notes:   HAS_DATA enables the data value compare (channel 1 only)

`timescale 1ns/1ps

module ubmu_chan_match #(
	parameter bit HAS_DATA = 1'b0
) (
	// Channel settings
	input  wire logic [31:0] condReg,
	input  wire logic [31:0] addrReg,
	input  wire logic [31:0] amaskReg,
	input  wire logic [31:0] dataReg,
	input  wire logic [31:0] dmaskReg,
	// Confirmed instruction fetch
	input  wire logic        fetchValid,
	input  wire logic [31:0] fetchAddr,
	// Classified operand access
	input  wire logic        opValid,
	input  wire logic [31:0] opAddr,
	input  wire logic        opIsWrite,
	input  wire logic [1:0]  opSizeEff,
	input  wire logic        opHasData,
	input  wire logic [63:0] opData,
	input  wire logic [7:0]  spaceId,
	// Results
	output logic             fetchHit,
	output logic             opHit
);

	logic        asidOk;
	logic        rwOk;
	logic        sizeOk;
	logic        dataOk;
	logic [31:0] laneMask;
	logic        loOk;
	logic        hiOk;
	logic [7:0]  space_id_compare_value;

	function automatic logic addrMatch(input logic [31:0] a,
		input logic [31:0] cmp, input logic [31:0] msk);
		addrMatch = ((a ^ cmp) & ~msk) == 32'h00000000;
	endfunction : addrMatch

	assign space_id_compare_value = condReg[ubmu_pkg::COND_AIV_LO +: ubmu_pkg::ASID_W];
	assign asidOk = !condReg[ubmu_pkg::COND_AIE] || spaceId == space_id_compare_value;

	// Reads and writes are enabled separately
	assign rwOk = opIsWrite ? condReg[ubmu_pkg::COND_WR]
		: condReg[ubmu_pkg::COND_RD];
	assign sizeOk = !condReg[ubmu_pkg::COND_SZ_EN]
		|| condReg[ubmu_pkg::COND_SZ_LO +: 2] == opSizeEff;

	always_comb
	begin
		if (opSizeEff == ubmu_pkg::OPSZ_BYTE)
			laneMask = ubmu_pkg::LANE_BYTE;
		else if (opSizeEff == ubmu_pkg::OPSZ_WORD)
			laneMask = ubmu_pkg::LANE_WORD;
		else
			laneMask = ubmu_pkg::LANE_LONG;
	end

	// Set mask bits drop out of the compare
	assign loOk = ((opData[31:0] ^ dataReg) & ~dmaskReg & laneMask)
		== 32'h00000000;
	assign hiOk = ((opData[63:32] ^ dataReg) & ~dmaskReg & laneMask)
		== 32'h00000000;

	// Quadword halves compare independently, either one will do
	assign dataOk = !HAS_DATA || !condReg[ubmu_pkg::COND_DBE]
		|| (opHasData && (loOk
		|| (opSizeEff == ubmu_pkg::OPSZ_QUAD && hiOk)));

	// Fetch ignores data compare; odd break address never matches
	assign fetchHit = fetchValid && condReg[ubmu_pkg::COND_CE]
		&& !condReg[ubmu_pkg::COND_OPCYC] && !addrReg[0]
		&& addrMatch(fetchAddr, addrReg, amaskReg) && asidOk;

	assign opHit = opValid && condReg[ubmu_pkg::COND_CE]
		&& condReg[ubmu_pkg::COND_OPCYC]
		&& addrMatch(opAddr, addrReg, amaskReg)
		&& rwOk && sizeOk && asidOk && dataOk;

endmodule : ubmu_chan_match

/* File: logic/ubmu_top.sv */
// Purpose: Two-channel user break match unit with register port
// Assumes: Core signals share clk; register reads answer one cycle later
// Notes:   One break request at a time; flags are sticky until software
//
// Functional notes
// - Control register bit 0 enables debug support; upper bits read zero.
// - Prefetch, write-back, purge read; allocate-store, invalidate write.
// - Operand accesses carry byte, word, longword or quadword size.
// - Prefetch, cache-block and allocate-store accesses count as longword.
// - Channels match size, cycle type, direction and masked address.
// - Identifier compare enable adds space identifier equality to match.
// - Channel 1 data compare against match data, masked bits excluded.
// - Execution-count enable includes the count register in the condition.
// - Sequence enable qualifies a break by the selected channel's flag.
// - Operation register picks break request and before/after timing.
// - A satisfied match sets the flag and may request a break.
// - Core block bit suppresses requests; flags still get set.
// - Flags stay set until software writes zero to them.
// - Simultaneous channel matches give one break request only.
// - Sequential mode sets flags per channel; clear releases first channel.
// - Fetch break needs break request enable; timing bit picks moment.
// - Fetch break address with bit 0 set never breaks.
// - Before-execution break only for instructions confirmed to execute.
// - Before-execution break in a delay slot precedes the branch.
// - After-execution break waits past delayed branch and its slot.
// - Channel 1 fetch matching ignores data compare settings.
// - Counted matches above one decrement; break on match once count is one.
// - Flag register write stores written value ANDed with flags.

`timescale 1ns/1ps

module ubmu_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdData,
	// Instruction fetch confirmed to execute
	input  wire logic        fetchExecValid,
	input  wire logic [31:0] fetchExecAddr,
	input  wire logic        fetchExecInSlot,
	// Instruction completion
	input  wire logic        retireValid,
	input  wire logic        retireDelayed,
	// Operand access
	input  wire logic        opValid,
	input  wire logic [31:0] opAddr,
	input  wire logic        opWrite,
	input  wire logic [1:0]  opSize,
	input  wire logic [2:0]  opKind,
	input  wire logic [63:0] opData,
	// Core state
	input  wire logic [7:0]  spaceId,
	input  wire logic        coreBlockBit,
	// Break request to core
	output logic             breakReq,
	output logic             breakAfterExec,
	output logic             breakAtBranch,
	output logic             debugSupportEnable
);

	// ********************************************************
	// Storage
	// ********************************************************
	logic [31:0] condReg    [2];
	logic [31:0] addrReg    [2];
	logic [31:0] amaskReg   [2];
	logic [31:0] operReg    [2];
	logic [31:0] data_reg;
	logic [31:0] dmask_reg;
	logic [11:0] count_reg;
	logic [1:0]  flags_reg;
	logic [1:0]  flags_next;
	logic        ctrl_reg;
	logic        pend_reg;
	logic        breakReq_reg;
	logic        breakAfter_reg;
	logic        breakBranch_reg;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;

	// ********************************************************
	// Per-channel match results
	// ********************************************************
	logic [1:0]  fetchHit;
	logic [1:0]  opHit;
	logic [1:0]  rawHit;
	logic [1:0]  seqOk;
	logic [1:0]  countOk;
	logic [1:0]  chanHit;
	logic [1:0]  beforeReq;
	logic [1:0]  afterReq;
	logic        opIsWrite;
	logic [1:0]  opSizeEff;
	logic        opHasData;
	logic        countEn;
	logic        countDec;
	logic        beforeAny;
	logic        relPend;
	logic        issue;

	// ********************************************************
	// Operand classification
	// ********************************************************
	always_comb
	begin
		opIsWrite = opWrite;
		opSizeEff = opSize;
		opHasData = 1'b1;
		case (opKind)
			ubmu_pkg::OPK_PREFETCH,
			ubmu_pkg::OPK_PURGE,
			ubmu_pkg::OPK_WRBACK:
			begin
				opIsWrite = 1'b0;
				opSizeEff = ubmu_pkg::OPSZ_LONG;
				opHasData = 1'b0;
			end
			ubmu_pkg::OPK_INVAL:
			begin
				opIsWrite = 1'b1;
				opSizeEff = ubmu_pkg::OPSZ_LONG;
				opHasData = 1'b0;
			end
			ubmu_pkg::OPK_ALLOC:
			begin
				opIsWrite = 1'b1;
				opSizeEff = ubmu_pkg::OPSZ_LONG;
			end
			// Test-and-set is one read or one write as the core reports it
			default:
			begin
				opIsWrite = opWrite;
				opSizeEff = opSize;
			end
		endcase
	end

	// ********************************************************
	// Channels
	// ********************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_chan
			localparam logic [7:0] CH_BASE =
				8'(gi * ubmu_pkg::CH_STRIDE);

			ubmu_chan_match #(
				.HAS_DATA (gi == 1)
			) u_match (
				.condReg    (condReg[gi]),
				.addrReg    (addrReg[gi]),
				.amaskReg   (amaskReg[gi]),
				.dataReg    (data_reg),
				.dmaskReg   (dmask_reg),
				.fetchValid (fetchExecValid),
				.fetchAddr  (fetchExecAddr),
				.opValid    (opValid),
				.opAddr     (opAddr),
				.opIsWrite  (opIsWrite),
				.opSizeEff  (opSizeEff),
				.opHasData  (opHasData),
				.opData     (opData),
				.spaceId    (spaceId),
				.fetchHit   (fetchHit[gi]),
				.opHit      (opHit[gi])
			);

			always_ff @(posedge clk)
			begin
				if (!reset_n)
				begin
					condReg[gi]  <= ubmu_pkg::RST_WORD;
					addrReg[gi]  <= ubmu_pkg::RST_WORD;
					amaskReg[gi] <= ubmu_pkg::RST_WORD;
					operReg[gi]  <= ubmu_pkg::RST_WORD;
				end
				else if (regWrite)
				begin
					if (regAddr == CH_BASE + ubmu_pkg::OFS_COND)
						condReg[gi] <= regWrData & ubmu_pkg::COND_MASK;
					else if (regAddr == CH_BASE + ubmu_pkg::OFS_ADDR)
						addrReg[gi] <= regWrData;
					else if (regAddr == CH_BASE + ubmu_pkg::OFS_AMASK)
						amaskReg[gi] <= regWrData;
					else if (regAddr == CH_BASE + ubmu_pkg::OFS_OPER)
						operReg[gi] <= regWrData & ubmu_pkg::OPER_MASK;
				end
			end

			assign rawHit[gi] = fetchHit[gi] | opHit[gi];

			// Second channel of a sequence waits for the first one's flag
			assign seqOk[gi] = !condReg[gi][ubmu_pkg::COND_MFE]
				|| flags_reg[condReg[gi][ubmu_pkg::COND_MFI]];

			assign chanHit[gi] = rawHit[gi] & seqOk[gi] & countOk[gi];

			// Fetch break only after the core confirms execution
			assign beforeReq[gi] = fetchHit[gi] && chanHit[gi]
				&& operReg[gi][ubmu_pkg::OPER_BIE]
				&& !operReg[gi][ubmu_pkg::OPER_AFTER];
			assign afterReq[gi] = chanHit[gi]
				&& operReg[gi][ubmu_pkg::OPER_BIE]
				&& (opHit[gi]
				|| operReg[gi][ubmu_pkg::OPER_AFTER]);
		end
	endgenerate

	// ********************************************************
	// Execution count, channel 1 only
	// ********************************************************
	assign countEn = condReg[1][ubmu_pkg::COND_EXEC_COUNT_ENABLE];
	assign countOk[0] = 1'b1;
	// Zero is treated like one so a cleared counter cannot wrap
	assign countOk[1] = !countEn
		|| count_reg <= ubmu_pkg::COUNT_ONE;
	assign countDec = countEn && rawHit[1] && seqOk[1]
		&& count_reg > ubmu_pkg::COUNT_ONE;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			count_reg <= ubmu_pkg::RST_WORD[11:0];
		else if (regWrite && regAddr == ubmu_pkg::OFS_COUNT)
			count_reg <= regWrData[11:0];
		else if (countDec)
			count_reg <= count_reg - ubmu_pkg::COUNT_ONE;
	end

	// ********************************************************
	// Data compare registers and control
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			data_reg  <= ubmu_pkg::RST_WORD;
			dmask_reg <= ubmu_pkg::RST_WORD;
		end
		else if (regWrite && regAddr == ubmu_pkg::OFS_DATA)
			data_reg <= regWrData;
		else if (regWrite && regAddr == ubmu_pkg::OFS_DMASK)
			dmask_reg <= regWrData;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			ctrl_reg <= 1'b0;
		else if (regWrite && regAddr == ubmu_pkg::OFS_CTRL)
			ctrl_reg <= regWrData[ubmu_pkg::CTRL_EN];
	end

	assign debugSupportEnable = ctrl_reg;

	// ********************************************************
	// Match flags
	// ********************************************************
	always_comb
	begin
		flags_next = flags_reg;
		if (regWrite && regAddr == ubmu_pkg::OFS_FLAGS)
			flags_next = flags_reg & regWrData[1:0];
		// A match in the clearing cycle still sets the flag
		flags_next = flags_next | chanHit;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			flags_reg <= ubmu_pkg::FLAGS_RST;
		else
			flags_reg <= flags_next;
	end

	// ********************************************************
	// Break request
	// ********************************************************
	assign beforeAny = |beforeReq;
	// Delayed branch and its slot hold the break to the target
	assign relPend = pend_reg && retireValid && !retireDelayed;
	assign issue = beforeAny || relPend;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			pend_reg <= 1'b0;
		else if (beforeAny || relPend || coreBlockBit)
			pend_reg <= 1'b0;
		else if (|afterReq)
			pend_reg <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			breakReq_reg    <= 1'b0;
			breakAfter_reg  <= 1'b0;
			breakBranch_reg <= 1'b0;
		end
		else
		begin
			// Blocked core would ignore it, so none is sent
			breakReq_reg    <= issue && !coreBlockBit;
			breakAfter_reg  <= issue && !coreBlockBit && !beforeAny;
			breakBranch_reg <= beforeAny && !coreBlockBit
				&& fetchExecInSlot;
		end
	end

	assign breakReq       = breakReq_reg;
	assign breakAfterExec = breakAfter_reg;
	assign breakAtBranch  = breakBranch_reg;

	// ********************************************************
	// Register read
	// ********************************************************
	always_comb
	begin
		rdData_next = ubmu_pkg::RST_WORD;
		if (regAddr == ubmu_pkg::OFS_COND)
			rdData_next = condReg[0];
		else if (regAddr == ubmu_pkg::OFS_ADDR)
			rdData_next = addrReg[0];
		else if (regAddr == ubmu_pkg::OFS_AMASK)
			rdData_next = amaskReg[0];
		else if (regAddr == ubmu_pkg::OFS_OPER)
			rdData_next = operReg[0];
		else if (regAddr == 8'(ubmu_pkg::CH_STRIDE) + ubmu_pkg::OFS_COND)
			rdData_next = condReg[1];
		else if (regAddr == 8'(ubmu_pkg::CH_STRIDE) + ubmu_pkg::OFS_ADDR)
			rdData_next = addrReg[1];
		else if (regAddr == 8'(ubmu_pkg::CH_STRIDE) + ubmu_pkg::OFS_AMASK)
			rdData_next = amaskReg[1];
		else if (regAddr == 8'(ubmu_pkg::CH_STRIDE) + ubmu_pkg::OFS_OPER)
			rdData_next = operReg[1];
		else if (regAddr == ubmu_pkg::OFS_DATA)
			rdData_next = data_reg;
		else if (regAddr == ubmu_pkg::OFS_DMASK)
			rdData_next = dmask_reg;
		else if (regAddr == ubmu_pkg::OFS_COUNT)
			rdData_next = {20'h00000, count_reg};
		else if (regAddr == ubmu_pkg::OFS_FLAGS)
			rdData_next = {30'h00000000, flags_reg};
		else if (regAddr == ubmu_pkg::OFS_CTRL)
			rdData_next = {31'h00000000, ctrl_reg};
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			rdData_reg <= ubmu_pkg::RST_WORD;
		else if (regRead)
			rdData_reg <= rdData_next;
		else
			rdData_reg <= ubmu_pkg::RST_WORD;
	end

	assign regRdData = rdData_reg;

endmodule : ubmu_top

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the break match unit
// Assumes: Core traffic comes from ubmu_core_model
// Notes:   Expected break counts of the operand kind loop are tracked in eb

`timescale 1ns/1ps

module tb;
	// ********************************************************
	// Signals and instances
	// ********************************************************
	logic        clk, reset_n, regWrite, regRead;
	logic [7:0]  regAddr, spaceId;
	logic [31:0] regWrData, regRdData, fetchExecAddr, opAddr, eb;
	logic        fetchExecValid, fetchExecInSlot, retireValid, breakReq;
	logic        retireDelayed, opValid, opWrite, coreBlockBit;
	logic [1:0]  opSize;
	logic [2:0]  opKind;
	logic [63:0] opData;
	logic        breakAfterExec, breakAtBranch, debugSupportEnable;
	int          fails, checksDone, cyc;

	ubmu_top ubmu_top_i (.*);
	ubmu_core_model ubmu_core_model_i (.*);

	// ********************************************************
	// Helpers
	// ********************************************************
	task complete_run;
		$display("checks %0d, mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task chk(input string n, input logic [31:0] got, input logic [31:0] e);
		checksDone++;
		if (got !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, got);
		end
	endtask : chk

	// Strobe lowered one edge later, so calls never collide
	task wr(input logic [7:0] a, input logic [31:0] d);
		{regAddr, regWrData, regWrite} <= {a, d, 1'b1};
		@(posedge clk);
		regWrite <= 1'b0;
		@(posedge clk);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		{regAddr, regRead} <= {a, 1'b1};
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk("regRdData", regRdData, e);
		@(posedge clk);
	endtask : rd

	task fx(input logic [31:0] a, input logic s);
		ubmu_core_model_i.fetch(a, s);
	endtask : fx

	task sb(input logic [31:0] b);
		@(posedge clk);
		chk("breaks", ubmu_core_model_i.brkCnt, b);
	endtask : sb

	task st(input logic [31:0] b, input logic [31:0] f);
		sb(b);
		rd(8'h2C, f);
		rd(8'h2C, f);
	endtask : st

	// ********************************************************
	// Scenarios
	// ********************************************************
	task t_regs;
		rd(8'h30, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rd(8'h30, 32'h1);
		chk("dbgEn", {31'h0, debugSupportEnable}, 32'h1);
		rd(8'hFC, 32'h0);
	endtask : t_regs

	task t_fetch;
		wr(8'h04, 32'h1000);
		wr(8'h0C, 32'h1);
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h1);
		fx(32'h1004, 1'b0);
		st(32'h0, 32'h0);
		fx(32'h1000, 1'b0);
		st(32'h1, 32'h1);
		chk("after", {31'h0, ubmu_core_model_i.lastAfter}, 32'h0);
		fx(32'h1000, 1'b1);
		st(32'h2, 32'h1);
		chk("branch", {31'h0, ubmu_core_model_i.lastBranch}, 32'h1);
		wr(8'h2C, 32'hFFFFFFFF);
		rd(8'h2C, 32'h1);
		wr(8'h2C, 32'h2);
		rd(8'h2C, 32'h0);
		ubmu_core_model_i.state(1'b1, 8'h00);
		fx(32'h1000, 1'b0);
		ubmu_core_model_i.state(1'b0, 8'h00);
		st(32'h2, 32'h1);
		wr(8'h2C, 32'h0);
		wr(8'h04, 32'h1001);
		fx(32'h1001, 1'b0);
		st(32'h2, 32'h0);
		wr(8'h04, 32'h2000);
		wr(8'h08, 32'hF0);
		fx(32'h20F0, 1'b0);
		st(32'h3, 32'h1);
		wr(8'h0C, 32'h3);
		fx(32'h2000, 1'b0);
		ubmu_core_model_i.retire(1'b1);
		sb(32'h3);
		ubmu_core_model_i.retire(1'b0);
		sb(32'h4);
		chk("after", {31'h0, ubmu_core_model_i.lastAfter}, 32'h1);
	endtask : t_fetch

	// Byte size given in the kind loop, so only longword-treated kinds can hit there
	task t_operand;
		wr(8'h00, 32'h0);
		wr(8'h2C, 32'h0);
		rd(8'h2C, 32'h0);
		wr(8'h14, 32'h3000);
		wr(8'h1C, 32'h1);
		wr(8'h10, 32'h6B);
		eb = 32'h4;
		for (int k = 0; k < 6; k++)
		begin
			ubmu_core_model_i.operand(32'h3000, 1'b0, 2'h0, 3'(k), 64'h0);
			ubmu_core_model_i.retire(1'b0);
			eb = eb + 32'((k > 0) && (k < 4));
			st(eb, {30'h0, k > 0, 1'b0});
		end
		wr(8'h20, 32'h12345678);
		wr(8'h24, 32'hFF);
		wr(8'h10, 32'hEB);
		ubmu_core_model_i.operand(32'h3000, 1'b0, 2'h2, 3'h0, 64'h123456FF);
		ubmu_core_model_i.retire(1'b0);
		sb(32'h8);
		ubmu_core_model_i.operand(32'h3000, 1'b0, 2'h2, 3'h0, 64'h2345678);
		ubmu_core_model_i.retire(1'b0);
		sb(32'h8);
	endtask : t_operand

	task t_multi;
		wr(8'h2C, 32'h0);
		wr(8'h04, 32'h4000);
		wr(8'h08, 32'h0);
		wr(8'h0C, 32'h1);
		wr(8'h00, 32'h1);
		wr(8'h14, 32'h4000);
		wr(8'h10, 32'h81);
		fx(32'h4000, 1'b0);
		st(32'h9, 32'h3);
		wr(8'h00, 32'h0);
		wr(8'h2C, 32'h0);
		wr(8'h28, 32'h2);
		wr(8'h10, 32'h101);
		fx(32'h4000, 1'b0);
		st(32'h9, 32'h0);
		rd(8'h28, 32'h1);
		fx(32'h4000, 1'b0);
		st(32'hA, 32'h2);
		wr(8'h10, 32'h401);
		wr(8'h04, 32'h6000);
		wr(8'h0C, 32'h0);
		fx(32'h4000, 1'b0);
		sb(32'hA);
		wr(8'h00, 32'h1);
		fx(32'h6000, 1'b0);
		sb(32'hA);
		fx(32'h4000, 1'b0);
		sb(32'hB);
		wr(8'h2C, 32'h2);
		fx(32'h4000, 1'b0);
		sb(32'hB);
		wr(8'h10, 32'h5A0201);
		fx(32'h4000, 1'b0);
		sb(32'hB);
		ubmu_core_model_i.state(1'b0, 8'h5A);
		fx(32'h4000, 1'b0);
		sb(32'hC);
	endtask : t_multi

	// ********************************************************
	// Clock, reset, sequence and timeout
	// ********************************************************
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			complete_run();
		end
	end

	initial
	begin
		{reset_n, regWrite, regRead, regAddr, regWrData} = 43'h0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_fetch();
		t_operand();
		t_multi();
		complete_run();
	end
endmodule : tb

/* File: testbench/ubmu_core_model.sv */
// Purpose: Core-side model for fetch, completion and operand traffic
// Assumes: Tasks are entered just after a rising clock edge
// Notes:   Counts break requests so the bench can judge them

`timescale 1ns/1ps

module ubmu_core_model (
	// Clock and break request
	input  wire logic        clk,
	input  wire logic        breakReq,
	input  wire logic        breakAfterExec,
	input  wire logic        breakAtBranch,
	// Fetch and completion
	output logic             fetchExecValid,
	output logic      [31:0] fetchExecAddr,
	output logic             fetchExecInSlot,
	output logic             retireValid,
	output logic             retireDelayed,
	// Operand access
	output logic             opValid,
	output logic      [31:0] opAddr,
	output logic             opWrite,
	output logic      [1:0]  opSize,
	output logic      [2:0]  opKind,
	output logic      [63:0] opData,
	// Core state
	output logic      [7:0]  spaceId,
	output logic             coreBlockBit
);
	// ********************************************************
	// Break bookkeeping and bus tasks
	// ********************************************************
	logic [31:0] brkCnt = 32'h0;
	logic        lastAfter = 1'b0;
	logic        lastBranch = 1'b0;

	always @(posedge clk)
	begin
		if (breakReq)
		begin
			brkCnt     <= brkCnt + 32'h1;
			lastAfter  <= breakAfterExec;
			lastBranch <= breakAtBranch;
		end
	end

	initial
	begin
		{fetchExecValid, fetchExecInSlot, retireValid, retireDelayed} = 4'h0;
		{opValid, opWrite, opSize, opKind} = 7'h0;
		{fetchExecAddr, opAddr, opData} = 128'h0;
		spaceId = 8'h0;
		coreBlockBit = 1'b0;
	end

	// Overrun fetches are never reported, only executed ones
	task automatic fetch(input logic [31:0] a, input logic s);
		fetchExecAddr   <= a;
		fetchExecInSlot <= s;
		fetchExecValid  <= 1'b1;
		@(posedge clk);
		fetchExecValid  <= 1'b0;
		fetchExecAddr   <= ~a;
		fetchExecInSlot <= ~s;
		@(posedge clk);
	endtask : fetch

	task automatic retire(input logic dly);
		retireDelayed <= dly;
		retireValid   <= 1'b1;
		@(posedge clk);
		retireValid   <= 1'b0;
		@(posedge clk);
	endtask : retire

	// Released address and data lines show inverted values; kind, size and direction keep theirs
	task automatic operand(input logic [31:0] a, input logic w,
		input logic [1:0] sz, input logic [2:0] k, input logic [63:0] dt);
		{opAddr, opWrite, opSize, opKind, opData} <= {a, w, sz, k, dt};
		opValid <= 1'b1;
		@(posedge clk);
		opValid <= 1'b0;
		opAddr  <= ~a;
		opData  <= ~dt;
		@(posedge clk);
	endtask : operand

	task automatic state(input logic b, input logic [7:0] s);
		coreBlockBit <= b;
		spaceId      <= s;
	endtask : state
endmodule : ubmu_core_model

/* File: testbench/ubmu_monitor.sv */
// Purpose: Port-level checks for the break match unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to ubmu_top; sees its ports only

`timescale 1ns/1ps

module ubmu_monitor (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [31:0] regRdData,
	// Core side
	input  wire logic        fetchExecValid,
	input  wire logic        fetchExecInSlot,
	input  wire logic        retireValid,
	input  wire logic        retireDelayed,
	input  wire logic        opValid,
	input  wire logic        coreBlockBit,
	// Break request
	input  wire logic        breakReq,
	input  wire logic        breakAfterExec,
	input  wire logic        breakAtBranch,
	input  wire logic        debugSupportEnable
);
	// ********************************************************
	// Sequences and properties
	// ********************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_rd;
		regRead && regAddr == ubmu_pkg::OFS_FLAGS;
	endsequence
	// Quiet core so no new hit can refill a flag
	sequence s_clr;
		regWrite && regAddr == ubmu_pkg::OFS_FLAGS &&
			regWrData[1:0] == 2'h0 && !fetchExecValid && !opValid;
	endsequence

	property p_ctrl_out;
		regWrite && regAddr == ubmu_pkg::OFS_CTRL
			|=> debugSupportEnable == $past(regWrData[0]);
	endproperty
	property p_ctrl_rd;
		regRead && regAddr == ubmu_pkg::OFS_CTRL
			|=> regRdData == {31'h0, $past(debugSupportEnable)};
	endproperty
	property p_flag_hold;
		s_rd ##1 !regWrite ##1 s_rd
			|=> (regRdData & $past(regRdData, 2)) == $past(regRdData, 2);
	endproperty
	property p_flag_clr;
		s_clr ##1 (!fetchExecValid && !opValid) ##1 s_rd
			|=> regRdData[1:0] == 2'h0;
	endproperty
	property p_block;
		coreBlockBit |=> !breakReq;
	endproperty
	property p_before;
		breakReq && !breakAfterExec |-> $past(fetchExecValid);
	endproperty
	property p_after;
		breakReq && breakAfterExec
			|-> $past(retireValid) && !$past(retireDelayed);
	endproperty
	property p_slot;
		breakAtBranch
			|-> breakReq && !breakAfterExec && $past(fetchExecInSlot);
	endproperty

	a_ctrl_out: assert property (p_ctrl_out)
		else $error("enable output differs from written bit");
	a_ctrl_rd: assert property (p_ctrl_rd)
		else $error("control read shows reserved bits");
	a_flag_hold: assert property (p_flag_hold)
		else $error("match flag dropped without a write");
	a_flag_clr: assert property (p_flag_clr)
		else $error("flags survive a write of zero");
	a_block: assert property (p_block)
		else $error("break requested while blocked");
	a_before: assert property (p_before)
		else $error("before break without a confirmed fetch");
	a_after: assert property (p_after)
		else $error("after break without a plain completion");
	a_slot: assert property (p_slot)
		else $error("branch break without a slot fetch");
endmodule : ubmu_monitor

bind ubmu_top ubmu_monitor ubmu_monitor_i (.*);
